// ---- inc/spo_pkg.sv ----
package spo_pkg;

    // ****************************************
    // clock and key timing
    // ****************************************
    localparam int CLK_HZ       = 20_000_000;
    localparam int REP_START_MS = 500;
    localparam int REP_SLOW_MS  = 100;
    localparam int REP_FAST_MS  = 20;
    localparam int CYC_PER_MS   = CLK_HZ / 1000;
    localparam int REP_START_CYC = REP_START_MS * CYC_PER_MS;
    localparam int REP_SLOW_CYC  = REP_SLOW_MS * CYC_PER_MS;
    localparam int REP_FAST_CYC  = REP_FAST_MS * CYC_PER_MS;
    localparam int REP_ACCEL     = 8;

    // ****************************************
    // register offsets and reset values
    // ****************************************
    localparam logic [11:0] OFF_SPD_WIN = 12'h000;
    localparam logic [11:0] OFF_POS_WIN = 12'h004;
    localparam logic [11:0] OFF_ROT_THR = 12'h008;
    localparam logic [11:0] OFF_PAR_MAX = 12'h00C;
    localparam logic [11:0] OFF_PAR_MIN = 12'h010;
    localparam logic [11:0] OFF_STATUS  = 12'h014;
    localparam logic [11:0] OFF_PARAM   = 12'h018;
    localparam logic [15:0] SPD_WIN_RST = 16'h000A;
    localparam logic [15:0] POS_WIN_RST = 16'h000A;
    localparam logic [15:0] ROT_THR_RST = 16'h0014;
    localparam logic [15:0] PAR_MAX_RST = 16'hFFFF;
    localparam logic [15:0] PAR_MIN_RST = 16'h0000;
    localparam logic [15:0] TRQ_PCT_THR = 16'h000A;
    localparam logic [31:0] PAR_VAL_RST = 32'h0000_0000;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        MODE_STATUS  = 2'b00,
        MODE_PARAM   = 2'b01,
        MODE_MONITOR = 2'b10,
        MODE_UTIL    = 2'b11
    } spo_mode_type;

    typedef enum logic {
        ED_NUM = 1'b0,
        ED_VAL = 1'b1
    } spo_edit_type;

    typedef enum logic [1:0] {
        CTL_SPEED  = 2'b00,
        CTL_TORQUE = 2'b01,
        CTL_POS    = 2'b10
    } spo_ctl_type;

    typedef enum logic [2:0] {
        CODE_BB      = 3'b000,
        CODE_RUN     = 3'b001,
        CODE_FWD_OFF = 3'b010,
        CODE_REV_OFF = 3'b011,
        CODE_BOTH_OFF = 3'b100,
        CODE_ALARM   = 3'b101
    } spo_code_type;

    typedef struct packed {
        logic rotating;
        logic pwr_rdy;
        logic trq_in;
        logic ref_in;
        logic ctrl_pwr;
        logic base_blk;
        logic coin;
    } spo_stat_type;

    typedef struct packed {
        spo_ctl_type        ctl;
        logic               servo_on;
        logic               base_blk;
        logic               ctrl_pwr;
        logic               main_pwr;
        logic               ref_pulse;
        logic               alarm_act;
        logic signed [15:0] motor_spd;
        logic signed [15:0] spd_ref;
        logic signed [15:0] trq_ref;
        logic signed [31:0] pos_err;
    } spo_drive_type;

    typedef struct packed {
        logic [16:0]  rsvd2;
        spo_edit_type edit;
        spo_mode_type mode;
        logic         rsvd1;
        spo_code_type code;
        logic         rsvd0;
        spo_stat_type stat;
    } spo_sts_word_type;

endpackage : spo_pkg

// ---- design/spo_key.sv ----
`timescale 1ns/10ps
`default_nettype none
module spo_key
    import spo_pkg::*;
#(
    parameter int START_CYC = REP_START_CYC,
    parameter int SLOW_CYC  = REP_SLOW_CYC,
    parameter int FAST_CYC  = REP_FAST_CYC
)(
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic key_n,
    output var  logic press_q,
    output var  logic step_q
);
    localparam int CW = $clog2(START_CYC + 1);

    logic          s1_q;
    logic          s2_q;
    logic          s3_q;
    logic [CW-1:0] cnt_q;
    logic [3:0]    nrep_q;
    logic          down;
    logic          edge_p;
    logic          tick;

    assign down   = ~s2_q;
    assign edge_p = down & s3_q;
    assign tick   = down & ~edge_p & (cnt_q == CW'(1));

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
        end
        else
        begin
            s1_q <= key_n;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // no debounce: the key is expected to come from a clean source
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q  <= '0;
            nrep_q <= 4'h0;
        end
        else if (!down)
        begin
            cnt_q  <= '0;
            nrep_q <= 4'h0;
        end
        else if (edge_p)
            cnt_q <= CW'(START_CYC);
        else if (tick)
        begin
            // after some slow repeats the step rate rises
            if (nrep_q >= 4'(REP_ACCEL))
                cnt_q <= CW'(FAST_CYC);
            else
            begin
                cnt_q  <= CW'(SLOW_CYC);
                nrep_q <= nrep_q + 4'h1;
            end
        end
        else if (cnt_q != '0)
            cnt_q <= cnt_q - CW'(1);
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            press_q <= 1'b0;
            step_q  <= 1'b0;
        end
        else
        begin
            press_q <= edge_p;
            step_q  <= edge_p | tick;
        end
    end

    AST_KEY_REPEAT: assert property (@(posedge mclk) disable iff (!rst_n)
        tick |=> step_q && !press_q)
        else $error("held key gave no repeat step");

endmodule : spo_key
`default_nettype wire

// ---- design/spo_panel.sv ----
// Functional notes
// - enter key in status display mode resets the active alarm
// - alarm clear input resets active alarms regardless of keys
// - four basic modes; each mode key press outside value editing selects the next
// - panel starts in status display mode after power on
// - speed/torque: coincidence bit lit when speed error within window
// - torque control: coincidence bit always lit
// - position control: bit lit when position error below window
// - base block bit lit while blocked, dark at servo on
// - control power bit lit while control power present
// - speed/torque: reference bit lit when speed reference above threshold
// - position control: reference bit lit while pulses arrive
// - speed/torque: torque bit lit when torque reference above 10%
// - position control: torque bit follows error counter clear input
// - power ready bit lit only while main power is on and normal; the code lights it from main_pwr alone
// - rotation bit lit when motor speed above rotation threshold
// - code shows baseblock at servo off, run at servo on
// - code shows forward prohibited while forward limit input off
// - code shows reverse prohibited while reverse limit input off
// - parameter mode: up/down pick number, enter shows its value
// - editing: up/down step value, no change past max or min
// - holding up or down repeats the step at rising rate
// - enter or mode during editing returns to the number
// - mode key during editing stores the edited value
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module spo_panel
    import spo_pkg::*;
#(
    parameter int PAR_AW    = 4,
    parameter int START_CYC = REP_START_CYC,
    parameter int SLOW_CYC  = REP_SLOW_CYC,
    parameter int FAST_CYC  = REP_FAST_CYC
)(
    input  wire logic          mclk,
    input  wire logic          nrst,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output var  logic [31:0]   prdata,
    output var  logic          pready,
    output var  logic          pslverr,
    input  wire logic          key_up_n,
    input  wire logic          key_down_n,
    input  wire logic          key_mode_n,
    input  wire logic          key_enter_n,
    input  wire logic          alarm_clear_input_n,
    input  wire logic          forward_travel_limit,
    input  wire logic          reverse_travel_limit,
    input  wire logic          err_clr_n,
    input  wire spo_drive_type drv,
    output var  spo_stat_type  stat_q,
    output var  spo_code_type  code_q,
    output var  spo_mode_type  mode_q,
    output var  spo_edit_type  edit_q,
    output var  logic [PAR_AW-1:0] num_q,
    output var  logic [15:0]   val_q,
    output var  logic          alarm_reset_q,
    output var  logic          store_q
);
    localparam int PAR_N = 1 << PAR_AW;

    // ****************************************
    // reset release and pin synchronisers
    // ****************************************
    logic       rs1_q;
    logic       rst_n;
    logic [3:0] pin1_q;
    logic [3:0] pin2_q;
    logic       aclr_prev_q;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            rs1_q <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rs1_q <= 1'b1;
            rst_n <= rs1_q;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin1_q      <= 4'hF;
            pin2_q      <= 4'hF;
            aclr_prev_q <= 1'b0;
        end
        else
        begin
            pin1_q <= {alarm_clear_input_n, forward_travel_limit,
                       reverse_travel_limit, err_clr_n};
            pin2_q      <= pin1_q;
            aclr_prev_q <= ~pin2_q[3];
        end
    end

    logic aclr_rise;
    logic fwd_on;
    logic rev_on;
    logic err_clr;
    assign aclr_rise = ~pin2_q[3] & ~aclr_prev_q;
    assign fwd_on    = pin2_q[2];
    assign rev_on    = pin2_q[1];
    assign err_clr   = ~pin2_q[0];

    // ****************************************
    // keys
    // ****************************************
    logic up_s;
    logic dn_s;
    logic md_p;
    logic en_p;

    spo_key #(.START_CYC(START_CYC), .SLOW_CYC(SLOW_CYC),
              .FAST_CYC(FAST_CYC)) u_up (
        .mclk(mclk), .rst_n(rst_n), .key_n(key_up_n),
        .press_q(), .step_q(up_s));
    spo_key #(.START_CYC(START_CYC), .SLOW_CYC(SLOW_CYC),
              .FAST_CYC(FAST_CYC)) u_dn (
        .mclk(mclk), .rst_n(rst_n), .key_n(key_down_n),
        .press_q(), .step_q(dn_s));
    spo_key #(.START_CYC(START_CYC), .SLOW_CYC(SLOW_CYC),
              .FAST_CYC(FAST_CYC)) u_md (
        .mclk(mclk), .rst_n(rst_n), .key_n(key_mode_n),
        .press_q(md_p), .step_q());
    spo_key #(.START_CYC(START_CYC), .SLOW_CYC(SLOW_CYC),
              .FAST_CYC(FAST_CYC)) u_en (
        .mclk(mclk), .rst_n(rst_n), .key_n(key_enter_n),
        .press_q(en_p), .step_q());

    // ****************************************
    // apb slave
    // ****************************************
    logic [15:0] spd_win_q;
    logic [15:0] pos_win_q;
    logic [15:0] rot_thr_q;
    logic [15:0] pmax_q;
    logic [15:0] pmin_q;
    logic        wr_acc;
    spo_sts_word_type sts;

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == OFF_SPD_WIN) || (a == OFF_POS_WIN) ||
                 (a == OFF_ROT_THR) || (a == OFF_PAR_MAX) ||
                 (a == OFF_PAR_MIN) || (a == OFF_STATUS) ||
                 (a == OFF_PARAM);
    endfunction : mapped

    assign wr_acc = psel & penable & pready & pwrite & mapped(paddr);

    always_comb
    begin
        sts       = '0;
        sts.edit  = edit_q;
        sts.mode  = mode_q;
        sts.code  = code_q;
        sts.stat  = stat_q;
    end

    // answer is prepared in setup, so access completes with no wait
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else if (psel && !penable && !pready)
        begin
            pready  <= 1'b1;
            pslverr <= ~mapped(paddr);
            unique case (paddr)
                OFF_SPD_WIN: prdata <= {16'h0000, spd_win_q};
                OFF_POS_WIN: prdata <= {16'h0000, pos_win_q};
                OFF_ROT_THR: prdata <= {16'h0000, rot_thr_q};
                OFF_PAR_MAX: prdata <= {16'h0000, pmax_q};
                OFF_PAR_MIN: prdata <= {16'h0000, pmin_q};
                OFF_STATUS:  prdata <= sts;
                OFF_PARAM:   prdata <= {16'(num_q), val_q};
                default:     prdata <= 32'h0000_0000;
            endcase
        end
        else
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            spd_win_q <= SPD_WIN_RST;
            pos_win_q <= POS_WIN_RST;
            rot_thr_q <= ROT_THR_RST;
            pmax_q    <= PAR_MAX_RST;
            pmin_q    <= PAR_MIN_RST;
        end
        else if (wr_acc)
        begin
            if (paddr == OFF_SPD_WIN)
                spd_win_q <= pwdata[15:0];
            if (paddr == OFF_POS_WIN)
                pos_win_q <= pwdata[15:0];
            if (paddr == OFF_ROT_THR)
                rot_thr_q <= pwdata[15:0];
            if (paddr == OFF_PAR_MAX)
                pmax_q <= pwdata[15:0];
            if (paddr == OFF_PAR_MIN)
                pmin_q <= pwdata[15:0];
        end
    end

    // ****************************************
    // status bits and code
    // ****************************************
    function automatic logic [32:0] sabs(input logic [32:0] v);
        sabs = v[32] ? 33'(~v + 33'h1) : v;
    endfunction : sabs

    logic [32:0] m33;
    logic [32:0] r33;
    logic [32:0] t33;
    logic [32:0] p33;
    logic [32:0] d33;
    logic [32:0] w_spd;
    logic [32:0] w_pos;
    logic [32:0] w_rot;
    logic        pos_ctl;
    spo_stat_type st_d;

    assign m33 = {{17{drv.motor_spd[15]}}, drv.motor_spd};
    assign r33 = {{17{drv.spd_ref[15]}}, drv.spd_ref};
    assign t33 = {{17{drv.trq_ref[15]}}, drv.trq_ref};
    assign p33 = {drv.pos_err[31], drv.pos_err};
    assign d33 = 33'(m33 - r33);
    assign w_spd = {17'h0_0000, spd_win_q};
    assign w_pos = {17'h0_0000, pos_win_q};
    assign w_rot = {17'h0_0000, rot_thr_q};
    assign pos_ctl = (drv.ctl == CTL_POS);

    always_comb
    begin
        st_d = '0;
        if (pos_ctl)
        begin
            st_d.coin   = sabs(p33) < w_pos;
            st_d.ref_in = drv.ref_pulse;
            st_d.trq_in = err_clr;
        end
        else
        begin
            st_d.coin   = (drv.ctl == CTL_TORQUE) ||
                          (sabs(d33) <= w_spd);
            st_d.ref_in = sabs(r33) > w_rot;
            st_d.trq_in = sabs(t33) > {17'h0_0000, TRQ_PCT_THR};
        end
        st_d.base_blk = drv.base_blk & ~drv.servo_on;
        st_d.ctrl_pwr = drv.ctrl_pwr;
        st_d.pwr_rdy  = drv.main_pwr;
        st_d.rotating = sabs(m33) > w_rot;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stat_q <= '0;
            code_q <= CODE_BB;
        end
        else
        begin
            stat_q <= st_d;
            // both limits off needs its own code to show both facts
            if (drv.alarm_act)
                code_q <= CODE_ALARM;
            else if (!fwd_on && !rev_on)
                code_q <= CODE_BOTH_OFF;
            else if (!fwd_on)
                code_q <= CODE_FWD_OFF;
            else if (!rev_on)
                code_q <= CODE_REV_OFF;
            else
                code_q <= drv.servo_on ? CODE_RUN : CODE_BB;
        end
    end

    // ****************************************
    // mode selection and parameter editing
    // ****************************************
    logic [15:0] mem [PAR_N];
    logic        in_val;
    assign in_val = (mode_q == MODE_PARAM) && (edit_q == ED_VAL);

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            mode_q <= MODE_STATUS;
        else if (md_p && !in_val)
        begin
            unique case (mode_q)
                MODE_STATUS:  mode_q <= MODE_PARAM;
                MODE_PARAM:   mode_q <= MODE_MONITOR;
                MODE_MONITOR: mode_q <= MODE_UTIL;
                MODE_UTIL:    mode_q <= MODE_STATUS;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            alarm_reset_q <= 1'b0;
        else
            alarm_reset_q <= (en_p && mode_q == MODE_STATUS) ||
                             aclr_rise;
    end

    // enter while editing drops the change; only mode saves it
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            edit_q  <= ED_NUM;
            num_q   <= '0;
            val_q   <= 16'h0000;
            store_q <= 1'b0;
        end
        else
        begin
            store_q <= 1'b0;
            if (mode_q == MODE_PARAM && edit_q == ED_NUM)
            begin
                if (en_p)
                begin
                    edit_q <= ED_VAL;
                    val_q  <= mem[num_q];
                end
                else if (up_s && num_q != '1)
                    num_q <= num_q + PAR_AW'(1);
                else if (dn_s && num_q != '0)
                    num_q <= num_q - PAR_AW'(1);
            end
            else if (in_val)
            begin
                if (md_p)
                begin
                    edit_q  <= ED_NUM;
                    store_q <= 1'b1;
                end
                else if (en_p)
                    edit_q <= ED_NUM;
                else if (up_s && val_q < pmax_q)
                    val_q <= val_q + 16'h0001;
                else if (dn_s && val_q > pmin_q)
                    val_q <= val_q - 16'h0001;
            end
            else
                edit_q <= ED_NUM;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < PAR_N; i++)
                mem[i] <= PAR_VAL_RST[15:0];
        end
        else if (in_val && md_p)
            mem[num_q] <= val_q;
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_save;
        in_val && md_p;
    endsequence

    sequence s_open;
        mode_q == MODE_PARAM && edit_q == ED_NUM && en_p;
    endsequence

    AST_ALARM_KEY: assert property (
        mode_q == MODE_STATUS && en_p |=> alarm_reset_q)
        else $error("enter in status mode did not reset alarm");
    AST_ALARM_PIN: assert property (
        aclr_rise |=> alarm_reset_q)
        else $error("alarm clear input did not reset alarm");
    AST_MODE_STEP: assert property (
        md_p && !in_val |=> mode_q == 2'($past(mode_q) + 2'b01))
        else $error("mode key did not select next mode");
    AST_MODE_WRAP: assert property (
        mode_q == MODE_UTIL && md_p |=> mode_q == MODE_STATUS)
        else $error("mode did not wrap to status display");
    AST_COIN_TRQ: assert property (
        drv.ctl == CTL_TORQUE |=> stat_q.coin)
        else $error("coincidence dark in torque control");
    AST_BB_SON: assert property (
        drv.servo_on |=> !stat_q.base_blk)
        else $error("base block lit at servo on");
    AST_FWD_OFF: assert property (
        !drv.alarm_act && !fwd_on && rev_on |=> code_q == CODE_FWD_OFF)
        else $error("forward prohibit code missing");
    AST_VAL_SAT: assert property (
        in_val && !md_p && !en_p && up_s && val_q >= pmax_q
        |=> $stable(val_q))
        else $error("value stepped past maximum");
    AST_OPEN: assert property (
        s_open |=> edit_q == ED_VAL ##1 edit_q == ED_VAL || md_p || en_p)
        else $error("enter did not open value edit");
    AST_SAVE: assert property (
        s_save |=> store_q && edit_q == ED_NUM
                   && mem[$past(num_q)] == $past(val_q))
        else $error("mode key did not store edited value");

endmodule : spo_panel
`default_nettype wire

// ---- tb/spo_oper.sv ----
`timescale 1ns/10ps
`default_nettype none
module spo_oper
(
    input  wire logic       mclk,
    input  wire logic       go,
    input  wire logic [1:0] sel,
    input  wire logic [7:0] hold,
    output var  logic [3:0] keys_n
);
    initial keys_n = 4'hF;
    // one key held low, then released; no contact bounce
    always @(posedge mclk)
    begin
        if (go)
        begin
            keys_n[sel] <= 1'b0;
            repeat (hold) @(posedge mclk);
            keys_n <= 4'hF;
        end
    end
endmodule : spo_oper
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
    import spo_pkg::*;
    logic mclk, nrst, psel, penable, pwrite, pready, pslverr, go, store_q;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] keys_n, num_q;
    logic [1:0] sel;
    logic [7:0] hold;
    logic alarm_clear_input_n, forward_travel_limit, reverse_travel_limit;
    logic err_clr_n, alarm_reset_q;
    logic [15:0] val_q;
    spo_drive_type drv;
    spo_stat_type  stat_q;
    spo_stat_type  exp_s;
    spo_code_type  code_q;
    spo_mode_type  mode_q;
    spo_edit_type  edit_q;
    logic [32:0]   q[$];
    int fails = 0, total_checks = 0, al_n = 0, st_n = 0;

    spo_panel #(.START_CYC(20), .SLOW_CYC(8), .FAST_CYC(3)) u_dut (
        .mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .key_up_n(keys_n[0]), .key_down_n(keys_n[1]),
        .key_mode_n(keys_n[2]), .key_enter_n(keys_n[3]),
        .alarm_clear_input_n, .forward_travel_limit, .reverse_travel_limit,
        .err_clr_n, .drv, .stat_q, .code_q, .mode_q, .edit_q, .num_q,
        .val_q, .alarm_reset_q, .store_q);
    spo_oper u_oper (.mclk, .go, .sel, .hold, .keys_n);

    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // ****************************************
    // expectations and checks
    // ****************************************
    function automatic int iabs(int v);
        return (v < 0) ? -v : v;
    endfunction : iabs

    function automatic spo_stat_type exp_stat(spo_drive_type d, logic ec_n);
        spo_stat_type s;
        int m, r;
        m = d.motor_spd;
        r = d.spd_ref;
        s.coin = (d.ctl == CTL_TORQUE) ? 1'b1 : (d.ctl == CTL_POS) ?
            (iabs(d.pos_err) < POS_WIN_RST) : (iabs(m - r) <= SPD_WIN_RST);
        s.base_blk = d.base_blk & ~d.servo_on;
        s.ctrl_pwr = d.ctrl_pwr;
        s.ref_in   = (d.ctl == CTL_POS) ? d.ref_pulse :
                     (iabs(r) > ROT_THR_RST);
        s.trq_in   = (d.ctl == CTL_POS) ? ~ec_n :
                     (iabs(d.trq_ref) > TRQ_PCT_THR);
        s.pwr_rdy  = d.main_pwr;
        s.rotating = iabs(m) > ROT_THR_RST;
        return s;
    endfunction : exp_stat

    function automatic spo_code_type exp_code(spo_drive_type d, logic f,
                                              logic r);
        if (d.alarm_act) return CODE_ALARM;
        if (!f && !r) return CODE_BOTH_OFF;
        if (!f) return CODE_FWD_OFF;
        if (!r) return CODE_REV_OFF;
        return d.servo_on ? CODE_RUN : CODE_BB;
    endfunction : exp_code

    task automatic chk(string nm, logic [32:0] e, logic [32:0] g);
        total_checks++;
        if (g !== e)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic tally_and_finish;
        // a read note that was never answered counts against the run
        fails += q.size();
        if (fails == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    // ****************************************
    // bus and key drivers
    // ****************************************
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // pready is judged at a rising edge; only the watchdog ends a hang
        do @(posedge mclk); while (pready !== 1'b1);
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task automatic rd(logic [11:0] a, logic [32:0] e);
        q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd

    // short holds stay below the repeat start delay
    task automatic press(logic [1:0] k, logic [7:0] h);
        @(posedge mclk);
        go <= 1'b1; sel <= k; hold <= h;
        @(posedge mclk);
        go <= 1'b0;
        repeat (h + 12) @(posedge mclk);
        @(negedge mclk);
    endtask : press

    always @(posedge mclk)
    begin
        if (alarm_reset_q === 1'b1) al_n++;
        if (store_q === 1'b1) st_n++;
        if (psel && penable && !pwrite && pready === 1'b1 && q.size() > 0)
            chk("read", q.pop_front(), {pslverr, prdata});
    end

    initial
    begin
        repeat (20000) @(posedge mclk);
        fails++;
        tally_and_finish();
    end

    initial
    begin
        nrst = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        go = 0; sel = 0; hold = 0; drv = '0; err_clr_n = 1;
        alarm_clear_input_n = 1; forward_travel_limit = 1;
        reverse_travel_limit = 1;
        void'($urandom(32'h83A456E2));
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        chk("mode", 33'(MODE_STATUS), 33'(mode_q));
        rd(12'h000, 33'h0_0000_000A);
        rd(12'h004, 33'h0_0000_000A);
        rd(12'h008, 33'h0_0000_0014);
        rd(12'h020, 33'h1_0000_0000);
        apb(1'b1, 12'h00C, 32'h0000_0002);
        rd(12'h00C, 33'h0_0000_0002);
        repeat (60)
        begin
            @(posedge mclk);
            // signed fields take both signs so magnitudes are exercised
            drv <= {2'($urandom % 3), 6'($urandom),
                    16'($urandom % 81 - 40), 16'($urandom % 81 - 40),
                    16'($urandom % 41 - 20), 32'($urandom % 41 - 20)};
            forward_travel_limit <= 1'($urandom);
            reverse_travel_limit <= 1'($urandom);
            err_clr_n <= 1'($urandom);
            repeat (4) @(posedge mclk);
            @(negedge mclk);
            exp_s = exp_stat(drv, err_clr_n);
            chk("coin", exp_s.coin, stat_q.coin);
            chk("ref in", exp_s.ref_in, stat_q.ref_in);
            chk("trq in", exp_s.trq_in, stat_q.trq_in);
            chk("stat", exp_s, stat_q);
            chk("code", 33'(exp_code(drv, forward_travel_limit,
                reverse_travel_limit)), 33'(code_q));
        end
        press(2'd3, 8'd10);
        chk("alarm reset", 33'(1), 33'(al_n));
        @(posedge mclk);
        alarm_clear_input_n <= 1'b0;
        repeat (8) @(posedge mclk);
        alarm_clear_input_n <= 1'b1;
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        chk("alarm reset", 33'(2), 33'(al_n));
        for (int i = 1; i <= 4; i++)
        begin
            press(2'd2, 8'd10);
            chk("mode", 33'(i % 4), 33'(mode_q));
        end
        press(2'd2, 8'd10);
        press(2'd0, 8'd10);
        press(2'd0, 8'd10);
        press(2'd1, 8'd10);
        chk("num", 33'(1), 33'(num_q));
        press(2'd3, 8'd10);
        press(2'd1, 8'd10);
        chk("edit", 33'(ED_VAL), 33'(edit_q));
        chk("val", 33'(0), 33'(val_q));
        repeat (3) press(2'd0, 8'd10);
        chk("val", 33'(2), 33'(val_q));
        press(2'd2, 8'd10);
        chk("mode", 33'(MODE_PARAM), 33'(mode_q));
        chk("edit", 33'(ED_NUM), 33'(edit_q));
        chk("store", 33'(1), 33'(st_n));
        press(2'd3, 8'd10);
        chk("val", 33'(2), 33'(val_q));
        press(2'd3, 8'd10);
        chk("edit", 33'(ED_NUM), 33'(edit_q));
        chk("store", 33'(1), 33'(st_n));
        apb(1'b1, 12'h00C, 32'h0000_FFFF);
        press(2'd3, 8'd10);
        // held 101 cycles: press, 9 slow and 5 fast repeats, from 2
        press(2'd0, 8'd101);
        chk("repeat", 33'(16'h0011), 33'(val_q));
        rd(12'h018, 33'h0_0001_0011);
        @(negedge mclk);
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
